// file: src/sdw_top.sv
// Write burst timing engine of a synchronous DRAM device
// What this block does
// - Eight-beat write when field is 00, or 01 with chop select high.
// - Field 10 forces chop-four bursts for every command.
// - Field 01 with chop select low gives a chop-four burst.
// - Chop-four recovery and write-to-read start four clocks after first data edge for field 01, first edge after last data clock for field 10.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
module sdw_top
  import sdw_pkg::*;
#(
  parameter int DQ_W = 16
)(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              link_clk,
  input  wire logic              cmd_write,
  input  wire logic              cmd_read,
  input  wire logic              cmd_precharge,
  input  wire logic              chop_select_address_bit,
  input  wire logic              termination_control_input,
  input  wire logic [2*DQ_W-1:0] din,
  output logic                   cap_valid,
  output logic      [2*DQ_W-1:0] cap_data,
  output logic                   cap_last
);

  localparam int IDX_W = $clog2(LAT_DEPTH);
  localparam int CFG_W = BL_W + 2 * LAT_W + 2 * CNT_W + 1;

  // ----------------------------------------------------------------
  // Link-side state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [LAT_DEPTH-1:0] pend;
    logic [LAT_DEPTH-1:0] pend_eight;
    sdw_lstate_t         st;
    logic [2:0]          beat;
    logic                eight;
    logic [CNT_W-1:0]    wtr_cnt;
    logic [CNT_W-1:0]    wr_cnt;
    logic [CNT_W-1:0]    term_cnt;
    logic                term_chop;
    logic                term_prev;
    logic                cap_valid;
    logic                cap_last;
    logic [2*DQ_W-1:0]   cap_data;
    logic [2*DQ_W-1:0]   first_word;
    logic [EV_W-1:0]     ev_tgl;
  } sdw_link_t;

  sdw_link_t          q;
  sdw_link_t          next_q;

  logic [BL_W-1:0]    cfg_bl;
  logic [LAT_W-1:0]   cfg_add_lat;
  logic [LAT_W-1:0]   cfg_col_lat;
  logic [CNT_W-1:0]   cfg_wtr;
  logic [CNT_W-1:0]   cfg_wr;
  logic [CFG_W-1:0]   cfg_l;
  logic [BL_W-1:0]    l_bl;
  logic [LAT_W-1:0]   l_add_lat;
  logic [LAT_W-1:0]   l_col_lat;
  logic [CNT_W-1:0]   l_wtr;
  logic [CNT_W-1:0]   l_wr;
  logic               lrst;
  logic [EV_W-1:0]    ev_tgl_s;
  logic [IDX_W:0]     wr_lat;
  logic [IDX_W-1:0]   lat_idx;
  logic               start;
  logic               start_eight;
  logic               cmd_eight;

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  // Mode and timing are quasi-static: change them only while the link is idle
  sdw_sync #(
    .W (CFG_W)
  ) u_cfg_sync (
    .clk  (link_clk),
    .din  ({rst, cfg_wr, cfg_wtr, cfg_col_lat, cfg_add_lat, cfg_bl}),
    .dout (cfg_l)
  );

  assign {lrst, l_wr, l_wtr, l_col_lat, l_add_lat, l_bl} = cfg_l;

  // Link events travel as toggles
  sdw_sync #(
    .W (EV_W)
  ) u_ev_sync (
    .clk  (mclk),
    .din  (q.ev_tgl),
    .dout (ev_tgl_s)
  );

  // First word is held from first beat until at least one burst later
  sdw_regs u_regs (
    .mclk     (mclk),
    .rst      (rst),
    .addr     (addr),
    .wdata    (wdata),
    .wr_en    (wr_en),
    .rd_en    (rd_en),
    .rdata    (rdata),
    .ev_tgl_s (ev_tgl_s),
    .word_in  (DATA_W'(q.first_word)),
    .cfg_bl   (cfg_bl),
    .cfg_add_lat (cfg_add_lat),
    .cfg_col_lat (cfg_col_lat),
    .cfg_wtr  (cfg_wtr),
    .cfg_wr   (cfg_wr)
  );

  // ----------------------------------------------------------------
  // Latency and burst decode
  // ----------------------------------------------------------------
  always_comb
  begin
    wr_lat      = (IDX_W + 1)'(l_add_lat) + (IDX_W + 1)'(l_col_lat);
    lat_idx     = (wr_lat == '0) ? '0 : IDX_W'(wr_lat - 1'b1);
    start       = q.pend[lat_idx];
    start_eight = q.pend_eight[lat_idx];
    cmd_eight   = sdw_is_eight(l_bl, chop_select_address_bit);
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_q            = q;
    next_q.pend       = {q.pend[LAT_DEPTH-2:0], cmd_write};
    next_q.pend_eight = {q.pend_eight[LAT_DEPTH-2:0], cmd_write & cmd_eight};
    next_q.cap_valid  = 1'b0;
    next_q.cap_last   = 1'b0;
    next_q.wtr_cnt    = (q.wtr_cnt != '0) ? q.wtr_cnt - 1'b1 : '0;
    next_q.wr_cnt     = (q.wr_cnt != '0) ? q.wr_cnt - 1'b1 : '0;
    case (q.st)
      SDW_IDLE:
      begin
        if (start)
        begin
          next_q.st         = SDW_BURST;
          next_q.beat       = 3'h1;
          next_q.eight      = start_eight;
          next_q.cap_valid  = 1'b1;
          next_q.cap_data   = din;
          next_q.first_word = din;
        end
      end
      SDW_BURST:
      begin
        if (q.beat < CLK_PER_BURST)
        begin
          next_q.beat      = q.beat + 1'b1;
          next_q.cap_valid = q.eight || (q.beat < CLK_CHOP_DATA);
          next_q.cap_data  = din;
          next_q.cap_last  = q.eight ? (q.beat == CLK_PER_BURST - 1'b1)
                                     : (q.beat == CLK_CHOP_DATA - 1'b1);
          // Fixed chop four: first edge after its last data clock
          if (l_bl == BL_FIXED4 && q.beat == CLK_CHOP_DATA)
          begin
            next_q.wtr_cnt = l_wtr;
            next_q.wr_cnt  = l_wr;
          end
        end
        else
        begin
          // Four clocks after first data edge for either per-command size
          if (l_bl != BL_FIXED4)
          begin
            next_q.wtr_cnt = l_wtr;
            next_q.wr_cnt  = l_wr;
          end
          next_q.ev_tgl[ST_DONE] = ~q.ev_tgl[ST_DONE];
          if (start)
          begin
            next_q.beat       = 3'h1;
            next_q.eight      = start_eight;
            next_q.cap_valid  = 1'b1;
            next_q.cap_data   = din;
            next_q.first_word = din;
          end
          else
            next_q.st = SDW_IDLE;
        end
      end
      default:
        next_q.st = SDW_IDLE;
    endcase

    // Host timing violations seen at the command pins
    if (cmd_read && q.wtr_cnt != '0)
      next_q.ev_tgl[ST_WTR] = ~q.ev_tgl[ST_WTR];
    if (cmd_precharge && q.wr_cnt != '0)
      next_q.ev_tgl[ST_WR] = ~q.ev_tgl[ST_WR];

    // Termination high time around chop-four writes
    next_q.term_prev = termination_control_input;
    if (termination_control_input)
    begin
      if (!q.term_prev)
        next_q.term_cnt = CNT_W'(1);
      else if (q.term_cnt != '1)
        next_q.term_cnt = q.term_cnt + 1'b1;
      if (cmd_write && !cmd_eight)
        next_q.term_chop = 1'b1;
    end
    else if (q.term_prev)
    begin
      if (q.term_chop && q.term_cnt < TERM_MIN_HI_CHP)
        next_q.ev_tgl[ST_TERM] = ~q.ev_tgl[ST_TERM];
      next_q.term_chop = 1'b0;
      next_q.term_cnt  = '0;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      q    <= '0;
      q.st <= SDW_IDLE;
    end
    else
      q <= next_q;
  end

  assign cap_valid = q.cap_valid;
  assign cap_data  = q.cap_data;
  assign cap_last  = q.cap_last;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_EIGHT_FIXED: assert property (@(posedge link_clk) disable iff (lrst)
    (cmd_write && l_bl == BL_FIXED8) |=> q.pend_eight[0])
    else $error("field 00 write not eight beats");

  AST_EIGHT_SELECT: assert property (@(posedge link_clk) disable iff (lrst)
    (cmd_write && l_bl == BL_PER_CMD && chop_select_address_bit) |=> q.pend_eight[0])
    else $error("per-command write with chop select high not eight beats");

  AST_CHOP_FIXED: assert property (@(posedge link_clk) disable iff (lrst)
    (cmd_write && l_bl == BL_FIXED4) |=> (q.pend[0] && !q.pend_eight[0]))
    else $error("field 10 write not chop four");

  AST_CHOP_SELECT: assert property (@(posedge link_clk) disable iff (lrst)
    (cmd_write && l_bl == BL_PER_CMD && !chop_select_address_bit) |=> !q.pend_eight[0])
    else $error("per-command write with chop select low not chop four");

  AST_CHOP_LENGTH: assert property (@(posedge link_clk) disable iff (lrst)
    (q.st == SDW_IDLE && start && !start_eight)
      |=> q.cap_valid ##1 (q.cap_valid && q.cap_last) ##1 !q.cap_valid ##1 !q.cap_valid)
    else $error("chop four burst captured wrong number of clocks");

  AST_RECOVERY_START: assert property (@(posedge link_clk) disable iff (lrst)
    (q.st == SDW_IDLE && start && l_bl != BL_FIXED4 && l_wr != '0 && l_wtr != '0)
      |-> ##4 (q.wr_cnt == '0 || q.st == SDW_BURST) ##1 (q.wr_cnt == l_wr && q.wtr_cnt == l_wtr))
    else $error("recovery not started four clocks after first data edge");

  AST_RECOVERY_CHOP: assert property (@(posedge link_clk) disable iff (lrst)
    (q.st == SDW_IDLE && start && l_bl == BL_FIXED4 && l_wr != '0 && l_wtr != '0)
      |-> ##3 (q.wr_cnt == l_wr && q.wtr_cnt == l_wtr))
    else $error("fixed chop four recovery not started after last data clock");

  AST_EIGHT_LENGTH: assert property (@(posedge link_clk) disable iff (lrst)
    (q.st == SDW_IDLE && start && start_eight) |=> q.cap_valid [*3] ##1 (q.cap_valid && q.cap_last))
    else $error("eight beat burst captured wrong number of clocks");

  AST_DATA_LATENCY: assert property (@(posedge link_clk) disable iff (lrst)
    (cmd_write && l_add_lat == ADD_LAT_RST && l_col_lat == COL_LAT_RST && q.st == SDW_IDLE && q.pend == '0)
      |-> ##6 q.cap_valid)
    else $error("write data not taken at write latency");

  // ----------------------------------------------------------------
  // Host timing checks
  // ----------------------------------------------------------------
  AST_READ_EARLY: assert property (@(posedge link_clk) disable iff (lrst)
    (cmd_read && q.wtr_cnt != '0) |=> (q.ev_tgl[ST_WTR] != $past(q.ev_tgl[ST_WTR])))
    else $error("early read not flagged");

  AST_PRE_EARLY: assert property (@(posedge link_clk) disable iff (lrst)
    (cmd_precharge && q.wr_cnt != '0) |=> (q.ev_tgl[ST_WR] != $past(q.ev_tgl[ST_WR])))
    else $error("early precharge not flagged");

  AST_TERM_SHORT: assert property (@(posedge link_clk) disable iff (lrst)
    (!termination_control_input && q.term_prev && q.term_chop && q.term_cnt < TERM_MIN_HI_CHP)
      |=> (q.ev_tgl[ST_TERM] != $past(q.ev_tgl[ST_TERM])))
    else $error("short termination high on chop write not flagged");

endmodule // sdw_top

// file: src/sdw_pkg.sv
// Constants, types and decode shared by the write burst timing block
package sdw_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam logic [7:0]  REG_MODE   = 8'h00;
  localparam logic [7:0]  REG_TIMING = 8'h04;
  localparam logic [7:0]  REG_STATUS = 8'h08;
  localparam logic [7:0]  REG_COUNT  = 8'h0c;
  localparam logic [7:0]  REG_WORD   = 8'h10;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int MODE_BL_LSB  = 0;
  localparam int MODE_ADD_LSB = 4;
  localparam int MODE_COL_LSB = 8;
  localparam int TM_WTR_LSB   = 0;
  localparam int TM_WR_LSB    = 8;
  localparam int ST_WIN_LSB   = 8;
  localparam int BL_W         = 2;
  localparam int LAT_W        = 4;
  localparam int CNT_W        = 8;
  localparam int EV_W         = 4;
  localparam int CNTR_W       = 16;

  // Status event bits
  localparam int ST_WTR  = 0;
  localparam int ST_WR   = 1;
  localparam int ST_TERM = 2;
  localparam int ST_DONE = 3;

  // Burst-length field codes
  localparam logic [1:0] BL_FIXED8  = 2'h0;
  localparam logic [1:0] BL_PER_CMD = 2'h1;
  localparam logic [1:0] BL_FIXED4  = 2'h2;

  // Reset values
  localparam logic [BL_W-1:0]  BL_RST  = 2'h0;
  localparam logic [LAT_W-1:0] ADD_LAT_RST = 4'h0;
  localparam logic [LAT_W-1:0] COL_LAT_RST = 4'h5;
  localparam logic [CNT_W-1:0] WTR_RST = 8'h04;
  localparam logic [CNT_W-1:0] WR_RST  = 8'h0c;

  // ----------------------------------------------------------------
  // Link timing in link clocks
  // ----------------------------------------------------------------
  localparam int         LAT_DEPTH      = 32;
  localparam logic [2:0] CLK_PER_BURST  = 3'h4;
  localparam logic [2:0] CLK_CHOP_DATA  = 3'h2;
  localparam logic [7:0] TERM_MIN_HI_CHP = 8'h04;

  typedef enum logic {SDW_IDLE, SDW_BURST} sdw_lstate_t;

  // Eight-beat burst decision for one write or read command
  function automatic logic sdw_is_eight(input logic [1:0] field, input logic chop_bit);
    case (field)
      BL_FIXED8:  return 1'b1;
      BL_PER_CMD: return chop_bit;
      BL_FIXED4:  return 1'b0;
      default:    return 1'b1;
    endcase
  endfunction

endpackage

// file: src/sdw_sync.sv
// Two-stage synchroniser for a bundle of quasi-static levels
`timescale 1ns/10ps
module sdw_sync
  import sdw_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sdw_sync_t;

  sdw_sync_t q;
  sdw_sync_t next_q;

  always_comb
  begin
    next_q.s1 = din;
    next_q.s2 = q.s1;
  end

  always_ff @(posedge clk)
  begin
    q <= next_q;
  end

  assign dout = q.s2;

endmodule // sdw_sync

// file: src/sdw_regs.sv
// Register file on the system clock: mode, timing, status, counters
`timescale 1ns/10ps
module sdw_regs
  import sdw_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic [EV_W-1:0]   ev_tgl_s,
  input  wire logic [DATA_W-1:0] word_in,
  output logic      [BL_W-1:0]   cfg_bl,
  output logic      [LAT_W-1:0]  cfg_add_lat,
  output logic      [LAT_W-1:0]  cfg_col_lat,
  output logic      [CNT_W-1:0]  cfg_wtr,
  output logic      [CNT_W-1:0]  cfg_wr
);

  typedef struct packed {
    logic [BL_W-1:0]   bl;
    logic [LAT_W-1:0]  add_lat;
    logic [LAT_W-1:0]  col_lat;
    logic [CNT_W-1:0]  wtr;
    logic [CNT_W-1:0]  wr;
    logic [EV_W-1:0]   sticky;
    logic [EV_W-1:0]   ev_prev;
    logic [CNTR_W-1:0] count;
    logic [DATA_W-1:0] word;
    logic [DATA_W-1:0] rdata;
  } sdw_regs_t;

  sdw_regs_t         q;
  sdw_regs_t         next_q;
  logic [EV_W-1:0]   ev_edge;
  logic [CNT_W-1:0]  window;
  logic [CNT_W-1:0]  lat_sum;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_q  = q;
    ev_edge = ev_tgl_s ^ q.ev_prev;
    lat_sum = CNT_W'(q.add_lat) + CNT_W'(q.col_lat);
    window  = (lat_sum == '0) ? '0 : lat_sum - 1'b1;
    next_q.ev_prev = ev_tgl_s;
    next_q.rdata   = '0;
    if (wr_en && addr == REG_MODE)
    begin
      next_q.bl  = wdata[MODE_BL_LSB +: BL_W];
      next_q.add_lat = wdata[MODE_ADD_LSB +: LAT_W];
      next_q.col_lat = wdata[MODE_COL_LSB +: LAT_W];
    end
    if (wr_en && addr == REG_TIMING)
    begin
      next_q.wtr = wdata[TM_WTR_LSB +: CNT_W];
      next_q.wr  = wdata[TM_WR_LSB +: CNT_W];
    end
    // Write one to clear; a new event wins over the clear
    if (wr_en && addr == REG_STATUS)
      next_q.sticky = q.sticky & ~wdata[EV_W-1:0];
    next_q.sticky = next_q.sticky | ev_edge;
    if (ev_edge[ST_DONE])
    begin
      next_q.count = q.count + 1'b1;
      next_q.word  = word_in;
    end
    if (rd_en)
    begin
      case (addr)
        REG_MODE:   next_q.rdata = DATA_W'({q.col_lat, q.add_lat, 2'h0, q.bl});
        REG_TIMING: next_q.rdata = DATA_W'({q.wr, q.wtr});
        REG_STATUS: next_q.rdata = DATA_W'({window, 4'h0, q.sticky});
        REG_COUNT:  next_q.rdata = DATA_W'(q.count);
        REG_WORD:   next_q.rdata = q.word;
        default:    next_q.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      q        <= '0;
      q.bl     <= BL_RST;
      q.add_lat <= ADD_LAT_RST;
      q.col_lat <= COL_LAT_RST;
      q.wtr    <= WTR_RST;
      q.wr     <= WR_RST;
    end
    else
      q <= next_q;
  end

  assign rdata   = q.rdata;
  assign cfg_bl  = q.bl;
  assign cfg_add_lat = q.add_lat;
  assign cfg_col_lat = q.col_lat;
  assign cfg_wtr = q.wtr;
  assign cfg_wr  = q.wr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ASYNC_WINDOW: assert property (@(posedge mclk) disable iff (rst)
    (rd_en && addr == REG_STATUS) |=> (rdata[ST_WIN_LSB +: CNT_W] == $past(window)))
    else $error("termination transition window not latency minus one");

  AST_STICKY_SET: assert property (@(posedge mclk) disable iff (rst)
    (ev_edge != '0) |=> ((q.sticky & $past(ev_edge)) == $past(ev_edge)))
    else $error("event lost against status clear");

endmodule // sdw_regs

// file: dv/sdw_host.sv
// Host controller model driving link commands, termination and write data
`timescale 1ns/10ps
module sdw_host
  import sdw_pkg::*;
#(
  parameter int DQ_W = 16
)(
  input  wire logic              link_clk,
  output logic                   cmd_write,
  output logic                   cmd_read,
  output logic                   cmd_precharge,
  output logic                   chop_select_address_bit,
  output logic                   termination_control_input,
  output logic      [2*DQ_W-1:0] din
);
  logic [DQ_W-1:0] lcnt;

  // ----------------------------------------------------------------
  // Data lines
  // ----------------------------------------------------------------
  // Pattern moves every clock, so a stale or shifted beat never matches
  initial lcnt = '0;
  always @(posedge link_clk) lcnt <= lcnt + 1'b1;
  assign din = {~lcnt, lcnt};

  initial
  begin
    cmd_write                 = 1'b0;
    cmd_read                  = 1'b0;
    cmd_precharge             = 1'b0;
    chop_select_address_bit   = 1'b0;
    termination_control_input = 1'b0;
  end

  // ----------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------
  // Kind is {precharge, read, write}; at returns the count seen at the command edge
  task automatic issue(input logic [2:0] kind, input logic chop, input int hi, input int dly,
                       output logic [DQ_W-1:0] at);
    @(posedge link_clk);
    repeat (dly) @(posedge link_clk);
    {cmd_precharge, cmd_read, cmd_write} <= kind;
    chop_select_address_bit              <= chop;
    termination_control_input            <= (hi > 0);
    @(posedge link_clk);
    at = lcnt;
    {cmd_precharge, cmd_read, cmd_write} <= 3'h0;
    chop_select_address_bit              <= ~chop;
    if (hi > 0)
    begin
      repeat (hi - 1) @(posedge link_clk);
      termination_control_input <= 1'b0;
    end
  endtask
endmodule // sdw_host

// file: dv/tb_top.sv
// Self-checking bench for the write burst timing block
`timescale 1ns/10ps
module tb_top
  import sdw_pkg::*;
();
  localparam int DQ_W = 16;
  localparam logic [ADDR_W-1:0] RA [6] = '{REG_MODE, REG_TIMING, REG_STATUS, REG_COUNT, REG_WORD, 8'h20};
  localparam logic [31:0]       RV [6] = '{32'h500, 32'hc04, 32'h400, 32'h0, 32'h0, 32'h0};
  // Burst cases: field, chop bit, additive, column, beats
  localparam logic [1:0] BL [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
  localparam logic       CB [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  localparam logic [3:0] ADL [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
  localparam logic [3:0] CW [6] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h4};
  localparam int         NB [6] = '{4, 4, 2, 2, 4, 4};
  // Timing cases: chop bit, termination clocks, second command, gap, status bits
  localparam logic       VC [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  localparam int         VH [9] = '{0, 0, 0, 0, 0, 0, 2, 6, 2};
  localparam logic [2:0] VK [9] = '{3'h2, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h0, 3'h0, 3'h0};
  localparam int         VD [9] = '{10, 10, 14, 10, 10, 16, 0, 0, 0};
  localparam logic [3:0] VB [9] = '{4'h1, 4'h1, 4'h0, 4'h2, 4'h2, 4'h0, 4'h4, 4'h0, 4'h0};
  // Fixed chop timing cases: second command, gap, status bits
  localparam logic [2:0] FK [4] = '{3'h2, 3'h2, 3'h4, 3'h4};
  localparam int         FD [4] = '{8, 10, 10, 12};
  localparam logic [3:0] FB [4] = '{4'h9, 4'h8, 4'ha, 4'h8};

  logic                mclk;
  logic                rst;
  logic                link_clk;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic                wr_en;
  logic                rd_en;
  logic [DATA_W-1:0]   rdata;
  logic                cmd_write;
  logic                cmd_read;
  logic                cmd_precharge;
  logic                chop_bit;
  logic                term;
  logic [2*DQ_W-1:0]   din;
  logic                cap_valid;
  logic [2*DQ_W-1:0]   cap_data;
  logic                cap_last;
  logic [2*DQ_W-1:0]   beats [$];
  int                  failures;
  int                  num_checks;
  int                  nlast;

  always #20 mclk = ~mclk;
  always #32 link_clk = ~link_clk;

  sdw_top #(.DQ_W(DQ_W)) dut_u (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .link_clk(link_clk), .cmd_write(cmd_write), .cmd_read(cmd_read),
    .cmd_precharge(cmd_precharge), .chop_select_address_bit(chop_bit),
    .termination_control_input(term), .din(din), .cap_valid(cap_valid),
    .cap_data(cap_data), .cap_last(cap_last)
  );

  sdw_host #(.DQ_W(DQ_W)) host_u (
    .link_clk(link_clk), .cmd_write(cmd_write), .cmd_read(cmd_read),
    .cmd_precharge(cmd_precharge), .chop_select_address_bit(chop_bit),
    .termination_control_input(term), .din(din)
  );

  // ----------------------------------------------------------------
  // Capture monitor
  // ----------------------------------------------------------------
  always @(posedge link_clk)
  begin
    if (cap_valid === 1'b1)
      beats.push_back(cap_data);
    if (cap_last === 1'b1)
      nlast++;
  end

  // ----------------------------------------------------------------
  // Bus tasks and compare
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [2*DQ_W-1:0] pat(input logic [DQ_W-1:0] c);
    return {~c, c};
  endfunction

  task automatic end_of_test();
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #400us;
    failures++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [DATA_W-1:0] v;
    logic [DQ_W-1:0]   at;
    logic [DQ_W-1:0]   at2;
    int                wlat;
    mclk = 1'b0; link_clk = 1'b0; rst = 1'b1; addr = '0; wdata = '0; wr_en = 1'b0; rd_en = 1'b0;
    failures = 0; num_checks = 0; nlast = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge link_clk);
    wr_reg(8'h20, 32'hffff_ffff);
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(RA[i], v);
      chk(v, RV[i]);
    end
    wr_reg(REG_TIMING, 32'h0604);
    rd_reg(REG_TIMING, v);
    chk(v, 32'h0604);
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(REG_MODE, {20'h0, CW[i], ADL[i], 2'h0, BL[i]});
      wr_reg(REG_STATUS, 32'hf);
      beats.delete();
      nlast = 0;
      host_u.issue(3'h1, CB[i], 0, 4, at);
      repeat (24) @(posedge link_clk);
      wlat = int'(ADL[i]) + int'(CW[i]);
      chk(beats.size(), NB[i]);
      for (int k = 0; k < beats.size(); k++)
        chk(beats[k], pat(DQ_W'(int'(at) + wlat + k)));
      chk(nlast, 1);
      rd_reg(REG_STATUS, v);
      chk(v, {16'h0, 8'(wlat - 1), 8'h08});
      rd_reg(REG_COUNT, v);
      chk(v, i + 1);
      rd_reg(REG_WORD, v);
      chk(v, pat(DQ_W'(int'(at) + wlat)));
    end
    wr_reg(REG_MODE, 32'h0501);
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(REG_STATUS, 32'hf);
      host_u.issue(3'h1, VC[i], VH[i], 4, at);
      if (VK[i] != 3'h0)
        host_u.issue(VK[i], 1'b0, 0, VD[i], at2);
      repeat (24) @(posedge link_clk);
      rd_reg(REG_STATUS, v);
      chk(v, {16'h0, 8'h04, 4'h0, VB[i] | 4'h8});
    end
    wr_reg(REG_MODE, 32'h0502);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(REG_STATUS, 32'hf);
      host_u.issue(3'h1, 1'b1, 0, 4, at);
      host_u.issue(FK[i], 1'b0, 0, FD[i], at2);
      repeat (24) @(posedge link_clk);
      rd_reg(REG_STATUS, v);
      chk(v, {16'h0, 8'h04, 4'h0, FB[i]});
    end
    end_of_test();
  end
endmodule // tb_top
